// ### include/ctf_defines.svh
// Constants of the contactless tunnel frame codec: frame layout, admin codes,
// register map and bit-count figures.
// Assumes inclusion by bare name from design files.
`ifndef CTF_DEFINES_SVH
`define CTF_DEFINES_SVH

// ----------------------------------------------------------------------------
// Tunnel command byte layout
// ----------------------------------------------------------------------------
`define CTF_PREFIX          3'b010
`define CTF_PREFIX_HI       7
`define CTF_PREFIX_LO       5
`define CTF_STRUCT_BIT      4
`define CTF_ADMIN_HI        3
`define CTF_ADMIN_LO        0

// ----------------------------------------------------------------------------
// Admin codes
// ----------------------------------------------------------------------------
`define CTF_ADM_NONE        4'h0
`define CTF_ADM_TYPE_A_SEL  4'h8
`define CTF_ADM_PASSIVE_FWD 4'h9
`define CTF_ADM_GOTO_INIT   4'h1
`define CTF_ADM_GOTO_HALT   4'h2

// ----------------------------------------------------------------------------
// Bit-count figures
// ----------------------------------------------------------------------------
`define CTF_BITS_PER_BYTE   16'h0008
`define CTF_BITS_PER_GROUP  16'h0009
`define CTF_ONE_BYTE_BITS   16'h0004

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define CTF_ADDR_W          8
`define CTF_ADDR_CTRL       8'h00
`define CTF_ADDR_STATUS     8'h04
`define CTF_CTRL_EN         0
`define CTF_CTRL_STRUCT     1
`define CTF_CTRL_ADM_LO     2
`define CTF_CTRL_ADM_HI     5
`define CTF_ST_TX_BUSY      0
`define CTF_ST_RX_BUSY      1
`define CTF_ST_INIT         2
`define CTF_ST_HALT         3
`define CTF_ST_DROP         4
`define CTF_ST_BAD          5
`define CTF_ST_LEN_LO       8
`define CTF_ST_ADM_LO       16
`define CTF_ST_ADM_HI       19

`endif

// ### include/ctf_pkg.sv
// Types of the contactless tunnel frame codec.
// Assumes nothing of its surroundings.
package ctf_pkg;

   // Builder of frames toward the card module.
   typedef enum logic [0:0] {
      BLD_COLLECT,
      BLD_SEND
   } ctf_bld_t;

   // Parser of frames from the card module.
   typedef enum logic [1:0] {
      CRD_HDR,
      CRD_PAY,
      CRD_SKIP,
      CRD_SEND
   } ctf_crd_t;

endpackage

// ### hw/ctf_bit_count.sv
// Number of RF bits carried by a tunnel payload of a given byte length.
// Assumes the length never exceeds the payload limit of the codec.
`timescale 1ns/1ps
`include "ctf_defines.svh"

module ctf_bit_count #(
   parameter int LW = 5,
   parameter int BW = 8
) (
   // Payload description
   input  wire logic [LW-1:0] len,
   input  wire logic          byte_aligned,
   // Result
   output logic [BW-1:0]      bits
);

   logic [15:0] raw;
   logic [15:0] groups;

   always_comb begin
      groups = (16'(len) * `CTF_BITS_PER_BYTE) / `CTF_BITS_PER_GROUP;
      if (byte_aligned) begin
         raw = 16'(len) * `CTF_BITS_PER_BYTE;
      end else if (len == LW'(0)) begin
         raw = 16'h0000;
      end else if (len == LW'(1)) begin
         raw = `CTF_ONE_BYTE_BITS;
      end else begin
         raw = groups * `CTF_BITS_PER_GROUP;
      end
      bits = raw[BW-1:0];
   end

endmodule

// ### hw/ctf_codec.sv
// Tunnel frame codec of the contactless front end, with an APB register slave.
// Assumes the RF core has stripped RF framing and runs anticollision itself,
// and that the link control layer delivers and accepts whole tunnel frames.
//
// How it works
// - RF framing is gone before tunnelling and re-added by the RF core.
// - error-detection bytes pass through the payload untouched.
// - type A anticollision stays in the RF core; no frames while disabled.
// - card supplies passive-mode init data; front end forwards with its code.
// - the payload carries RF data received or to be transmitted.
// - command bit 4 picks type A aligned (0) or byte aligned (1).
// - unused bits of the last type A byte are sent as zero.
// - byte aligned last byte holds one to eight bits from the LSB.
// - front-end admin codes are 0000 none, 1000 type A, 1001 passive.
// - the front end never sends a reserved admin code.
// - a payload is handled whatever admin code comes with it.
// - received codes are decoded with the card module's meanings.
// - RF frames longer than one tunnel payload are not tunnelled.
// - type A bits to RF: 0, 4, else eight per RF byte rounded down to a multiple of nine.
// - a card frame with payload goes out on RF; without, nothing.
`timescale 1ns/1ps
`include "ctf_defines.svh"

module ctf_codec #(
   parameter int MAX_PAYLOAD = 29,
   parameter int LW          = $clog2(MAX_PAYLOAD + 1),
   parameter int BW          = 8
) (
   // Clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // APB slave
   input  wire logic [`CTF_ADDR_W-1:0] paddr,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           pwdata,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Received RF data, framing removed
   input  wire logic                  rf_rx_valid,
   input  wire logic [7:0]            rf_rx_data,
   input  wire logic                  rf_rx_last,
   input  wire logic [3:0]            rf_rx_nbits,
   output logic                       rf_rx_ready,
   // Tunnel frames toward the card module
   output logic                       lk_tx_valid,
   output logic [7:0]                 lk_tx_data,
   output logic                       lk_tx_last,
   input  wire logic                  lk_tx_ready,
   // Tunnel frames from the card module
   input  wire logic                  lk_rx_valid,
   input  wire logic [7:0]            lk_rx_data,
   input  wire logic                  lk_rx_last,
   output logic                       lk_rx_ready,
   // RF data to transmit
   output logic                       rf_tx_valid,
   output logic [7:0]                 rf_tx_data,
   output logic                       rf_tx_last,
   output logic [BW-1:0]              rf_tx_bits,
   input  wire logic                  rf_tx_ready,
   // RF protocol state requests
   output logic                       rf_goto_init,
   output logic                       rf_goto_halt
);

   // -------------------------------------------------------------------------
   // Functions
   // -------------------------------------------------------------------------
   function automatic logic [7:0] keep_low_bits(input logic [7:0] d, input logic [3:0] n);
      logic [7:0] m;
      m = 8'h00;
      for (int i = 0; i < 8; i++) begin
         m[i] = (i < n);
      end
      return d & m;
   endfunction

   function automatic logic [3:0] legal_admin(input logic [3:0] code);
      logic [3:0] r;
      r = `CTF_ADM_NONE;
      if (code == `CTF_ADM_TYPE_A_SEL || code == `CTF_ADM_PASSIVE_FWD) begin
         r = code;
      end
      return r;
   endfunction

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   localparam logic [LW-1:0] MAXL = LW'(MAX_PAYLOAD);

   logic [7:0]         bbuf [MAX_PAYLOAD];
   logic [7:0]         cbuf [MAX_PAYLOAD];

   ctf_pkg::ctf_bld_t  bld_q, bld_d;
   logic [LW-1:0]      blen_q, blen_d, bidx_q, bidx_d;
   logic               bovf_q, bovf_d;
   logic               rrdy_q, rrdy_d;
   logic               tvld_q, tvld_d, tlast_q, tlast_d;
   logic [7:0]         tdat_q, tdat_d;
   logic               b_we;
   logic [7:0]         b_wd;
   logic               adm_clr;

   ctf_pkg::ctf_crd_t  crd_q, crd_d;
   logic [LW-1:0]      clen_q, clen_d, cidx_q, cidx_d;
   logic               covf_q, covf_d, cstr_q, cstr_d;
   logic [3:0]         cadm_q, cadm_d;
   logic               crdy_q, crdy_d;
   logic               xvld_q, xvld_d, xlast_q, xlast_d;
   logic [7:0]         xdat_q, xdat_d;
   logic [BW-1:0]      xbits_q, xbits_d, cbits;
   logic               c_we;
   logic               init_q, init_d, halt_q, halt_d;
   logic               drop_evt, bad_evt;

   logic               en_q, en_d, str_q, str_d;
   logic [3:0]         adm_q, adm_d;
   logic [3:0]         st_q, st_d;
   logic [31:0]        prdata_q, prdata_d;
   logic               pready_q, pready_d, pslverr_q, pslverr_d;

   // -------------------------------------------------------------------------
   // Frame builder toward the card module
   // -------------------------------------------------------------------------
   always_comb begin
      bld_d   = bld_q;
      blen_d  = blen_q;
      bidx_d  = bidx_q;
      bovf_d  = bovf_q;
      rrdy_d  = rrdy_q;
      tvld_d  = tvld_q;
      tdat_d  = tdat_q;
      tlast_d = tlast_q;
      b_we    = 1'b0;
      b_wd    = rf_rx_data;
      adm_clr = 1'b0;
      drop_evt = 1'b0;
      unique case (bld_q)
         ctf_pkg::BLD_COLLECT: begin
            rrdy_d = en_q;
            if (rf_rx_valid && rrdy_q) begin
               if (rf_rx_last) begin
                  b_wd = keep_low_bits(rf_rx_data, rf_rx_nbits);
               end
               if (blen_q == MAXL) begin
                  bovf_d = 1'b1;
               end else begin
                  b_we   = 1'b1;
                  blen_d = blen_q + LW'(1);
               end
               if (rf_rx_last) begin
                  if (bovf_d) begin
                     drop_evt = 1'b1;
                     blen_d   = '0;
                     bovf_d   = 1'b0;
                  end else begin
                     bld_d   = ctf_pkg::BLD_SEND;
                     rrdy_d  = 1'b0;
                     tvld_d  = 1'b1;
                     tdat_d  = {`CTF_PREFIX, str_q, legal_admin(adm_q)};
                     tlast_d = 1'b0;
                     bidx_d  = '0;
                     adm_clr = 1'b1;
                  end
               end
            end
         end
         ctf_pkg::BLD_SEND: begin
            rrdy_d = 1'b0;
            if (tvld_q && lk_tx_ready) begin
               if (tlast_q) begin
                  tvld_d  = 1'b0;
                  tlast_d = 1'b0;
                  blen_d  = '0;
                  bld_d   = ctf_pkg::BLD_COLLECT;
               end else begin
                  tdat_d  = bbuf[bidx_q];
                  tlast_d = (bidx_q == blen_q - LW'(1));
                  bidx_d  = bidx_q + LW'(1);
               end
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bld_q   <= ctf_pkg::BLD_COLLECT;
         blen_q  <= '0;
         bidx_q  <= '0;
         bovf_q  <= 1'b0;
         rrdy_q  <= 1'b0;
         tvld_q  <= 1'b0;
         tdat_q  <= 8'h00;
         tlast_q <= 1'b0;
      end else begin
         bld_q   <= bld_d;
         blen_q  <= blen_d;
         bidx_q  <= bidx_d;
         bovf_q  <= bovf_d;
         rrdy_q  <= rrdy_d;
         tvld_q  <= tvld_d;
         tdat_q  <= tdat_d;
         tlast_q <= tlast_d;
      end
   end

   always_ff @(posedge pclk) begin
      if (b_we) begin
         bbuf[blen_q] <= b_wd;
      end
      if (c_we) begin
         cbuf[clen_q] <= lk_rx_data;
      end
   end

   // -------------------------------------------------------------------------
   // Frame parser from the card module
   // -------------------------------------------------------------------------
   ctf_bit_count #(
      .LW (LW),
      .BW (BW)
   ) u_bit_count (
      .len          (clen_d),
      .byte_aligned (cstr_d),
      .bits         (cbits)
   );

   always_comb begin
      crd_d   = crd_q;
      clen_d  = clen_q;
      cidx_d  = cidx_q;
      covf_d  = covf_q;
      cstr_d  = cstr_q;
      cadm_d  = cadm_q;
      crdy_d  = crdy_q;
      xvld_d  = xvld_q;
      xdat_d  = xdat_q;
      xlast_d = xlast_q;
      xbits_d = xbits_q;
      c_we    = 1'b0;
      init_d  = 1'b0;
      halt_d  = 1'b0;
      bad_evt = 1'b0;
      unique case (crd_q)
         ctf_pkg::CRD_HDR, ctf_pkg::CRD_PAY, ctf_pkg::CRD_SKIP: begin
            crdy_d = en_q;
            if (lk_rx_valid && crdy_q) begin
               if (crd_q == ctf_pkg::CRD_HDR) begin
                  if (lk_rx_data[`CTF_PREFIX_HI:`CTF_PREFIX_LO] != `CTF_PREFIX) begin
                     bad_evt = 1'b1;
                     crd_d   = lk_rx_last ? ctf_pkg::CRD_HDR : ctf_pkg::CRD_SKIP;
                  end else begin
                     cstr_d = lk_rx_data[`CTF_STRUCT_BIT];
                     cadm_d = lk_rx_data[`CTF_ADMIN_HI:`CTF_ADMIN_LO];
                     clen_d = '0;
                     covf_d = 1'b0;
                     crd_d  = ctf_pkg::CRD_PAY;
                  end
               end else if (crd_q == ctf_pkg::CRD_PAY) begin
                  if (clen_q == MAXL) begin
                     covf_d = 1'b1;
                  end else begin
                     c_we   = 1'b1;
                     clen_d = clen_q + LW'(1);
                  end
               end
               if (lk_rx_last && crd_d != ctf_pkg::CRD_SKIP && !bad_evt) begin
                  init_d = (cadm_d == `CTF_ADM_GOTO_INIT);
                  halt_d = (cadm_d == `CTF_ADM_GOTO_HALT);
                  crd_d  = ctf_pkg::CRD_HDR;
                  if (covf_d) begin
                     clen_d = '0;
                  end else if (clen_d != '0) begin
                     crd_d   = ctf_pkg::CRD_SEND;
                     crdy_d  = 1'b0;
                     xvld_d  = 1'b1;
                     xdat_d  = (crd_q == ctf_pkg::CRD_PAY && clen_q == '0) ? lk_rx_data : cbuf[0];
                     xlast_d = (clen_d == LW'(1));
                     xbits_d = cbits;
                     cidx_d  = LW'(1);
                  end
               end else if (lk_rx_last) begin
                  crd_d = ctf_pkg::CRD_HDR;
               end
            end
         end
         ctf_pkg::CRD_SEND: begin
            crdy_d = 1'b0;
            if (xvld_q && rf_tx_ready) begin
               if (xlast_q) begin
                  xvld_d  = 1'b0;
                  xlast_d = 1'b0;
                  crd_d   = ctf_pkg::CRD_HDR;
               end else begin
                  xdat_d  = cbuf[cidx_q];
                  xlast_d = (cidx_q == clen_q - LW'(1));
                  cidx_d  = cidx_q + LW'(1);
               end
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crd_q   <= ctf_pkg::CRD_HDR;
         clen_q  <= '0;
         cidx_q  <= '0;
         covf_q  <= 1'b0;
         cstr_q  <= 1'b0;
         cadm_q  <= `CTF_ADM_NONE;
         crdy_q  <= 1'b0;
         xvld_q  <= 1'b0;
         xdat_q  <= 8'h00;
         xlast_q <= 1'b0;
         xbits_q <= '0;
         init_q  <= 1'b0;
         halt_q  <= 1'b0;
      end else begin
         crd_q   <= crd_d;
         clen_q  <= clen_d;
         cidx_q  <= cidx_d;
         covf_q  <= covf_d;
         cstr_q  <= cstr_d;
         cadm_q  <= cadm_d;
         crdy_q  <= crdy_d;
         xvld_q  <= xvld_d;
         xdat_q  <= xdat_d;
         xlast_q <= xlast_d;
         xbits_q <= xbits_d;
         init_q  <= init_d;
         halt_q  <= halt_d;
      end
   end

   // -------------------------------------------------------------------------
   // APB registers
   // -------------------------------------------------------------------------
   always_comb begin
      logic acc_done;
      logic hit_ctrl;
      logic hit_st;
      acc_done  = psel && penable && pready_q;
      hit_ctrl  = (paddr == `CTF_ADDR_CTRL);
      hit_st    = (paddr == `CTF_ADDR_STATUS);
      en_d      = en_q;
      str_d     = str_q;
      adm_d     = adm_clr ? `CTF_ADM_NONE : adm_q;
      st_d      = st_q;
      pready_d  = psel && penable && !pready_q;
      prdata_d  = 32'h0000_0000;
      pslverr_d = 1'b0;
      if (acc_done && pwrite && hit_ctrl) begin
         en_d  = pwdata[`CTF_CTRL_EN];
         str_d = pwdata[`CTF_CTRL_STRUCT];
         adm_d = pwdata[`CTF_CTRL_ADM_HI:`CTF_CTRL_ADM_LO];
      end
      if (acc_done && pwrite && hit_st) begin
         st_d = st_q & ~pwdata[`CTF_ST_BAD:`CTF_ST_INIT];
      end
      st_d = st_d | {bad_evt, drop_evt, halt_d, init_d};
      if (pready_d) begin
         pslverr_d = !(hit_ctrl || hit_st);
         if (hit_ctrl) begin
            prdata_d[`CTF_CTRL_EN]                      = en_q;
            prdata_d[`CTF_CTRL_STRUCT]                  = str_q;
            prdata_d[`CTF_CTRL_ADM_HI:`CTF_CTRL_ADM_LO] = adm_q;
         end
         if (hit_st) begin
            prdata_d[`CTF_ST_TX_BUSY]                 = (bld_q == ctf_pkg::BLD_SEND);
            prdata_d[`CTF_ST_RX_BUSY]                 = (crd_q != ctf_pkg::CRD_HDR);
            prdata_d[`CTF_ST_BAD:`CTF_ST_INIT]        = st_q;
            prdata_d[`CTF_ST_LEN_LO +: LW]            = clen_q;
            prdata_d[`CTF_ST_ADM_HI:`CTF_ST_ADM_LO]   = cadm_q;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q      <= 1'b0;
         str_q     <= 1'b0;
         adm_q     <= `CTF_ADM_NONE;
         st_q      <= 4'h0;
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         en_q      <= en_d;
         str_q     <= str_d;
         adm_q     <= adm_d;
         st_q      <= st_d;
         pready_q  <= pready_d;
         prdata_q  <= prdata_d;
         pslverr_q <= pslverr_d;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   assign prdata       = prdata_q;
   assign pready       = pready_q;
   assign pslverr      = pslverr_q;
   assign rf_rx_ready  = rrdy_q;
   assign lk_tx_valid  = tvld_q;
   assign lk_tx_data   = tdat_q;
   assign lk_tx_last   = tlast_q;
   assign lk_rx_ready  = crdy_q;
   assign rf_tx_valid  = xvld_q;
   assign rf_tx_data   = xdat_q;
   assign rf_tx_last   = xlast_q;
   assign rf_tx_bits   = xbits_q;
   assign rf_goto_init = init_q;
   assign rf_goto_halt = halt_q;

endmodule

// ### bench/ctf_codec_properties.sv
// Port checks of the tunnel frame codec.
// Assumes binding into ctf_codec with its one clock and active-low reset.
`timescale 1ns/1ps
module ctf_codec_properties #(
   parameter int MAX_PAYLOAD = 29,
   parameter int BW          = 8
) (
   // Clock, reset and APB
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic [7:0]    paddr,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pready,
   input wire logic          pslverr,
   // RF side
   input wire logic          rf_rx_valid,
   input wire logic          rf_rx_ready,
   input wire logic          rf_rx_last,
   input wire logic          rf_tx_valid,
   input wire logic [BW-1:0] rf_tx_bits,
   input wire logic          rf_goto_init,
   input wire logic          rf_goto_halt,
   // Link side
   input wire logic          lk_tx_valid,
   input wire logic [7:0]    lk_tx_data,
   input wire logic          lk_tx_ready
);
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic       rx_end;
   assign rx_end = rf_rx_valid && rf_rx_ready && rf_rx_last;
   // Counts RF bytes taken ahead of the last one.
   always_comb begin
      cnt_d = cnt_q;
      if (rf_rx_valid && rf_rx_ready)
         cnt_d = rf_rx_last ? 8'h00 : cnt_q + 8'h01;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cnt_q <= 8'h00;
      else
         cnt_q <= cnt_d;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_apb_wait; psel && !penable |=> !pready ##1 pready; endproperty
   a_apb_wait: assert property (p_apb_wait) else $error("late pready");
   property p_apb_err; pready |-> pslverr == (paddr != 8'h00 && paddr != 8'h04); endproperty
   a_apb_err: assert property (p_apb_err) else $error("bad pslverr");
   property p_hdr; rx_end && cnt_q < MAX_PAYLOAD |=> lk_tx_valid && lk_tx_data[7:5] == 3'b010; endproperty
   a_hdr: assert property (p_hdr) else $error("no header");
   property p_drop; rx_end && cnt_q >= MAX_PAYLOAD |=> !lk_tx_valid; endproperty
   a_drop: assert property (p_drop) else $error("oversize sent");
   property p_adm; $rose(lk_tx_valid) |-> lk_tx_data[3:0] inside {4'h0, 4'h8, 4'h9}; endproperty
   a_adm: assert property (p_adm) else $error("reserved code");
   property p_hold; lk_tx_valid && !lk_tx_ready |=> lk_tx_valid && $stable(lk_tx_data); endproperty
   a_hold: assert property (p_hold) else $error("link byte lost");
   property p_goto; rf_goto_init || rf_goto_halt |-> !(rf_goto_init && rf_goto_halt) ##1 !rf_goto_init; endproperty
   a_goto: assert property (p_goto) else $error("bad goto pulse");
   property p_bits; rf_tx_valid |-> rf_tx_bits != 0 && (rf_tx_bits % 9 == 0 || rf_tx_bits % 8 == 0 ||
      rf_tx_bits == 4); endproperty
   a_bits: assert property (p_bits) else $error("bad bit count");
endmodule
bind ctf_codec ctf_codec_properties #(.MAX_PAYLOAD(MAX_PAYLOAD), .BW(BW)) u_props (.pclk, .presetn, .paddr,
   .psel, .penable, .pready, .pslverr, .rf_rx_valid, .rf_rx_ready, .rf_rx_last, .rf_tx_valid, .rf_tx_bits,
   .rf_goto_init, .rf_goto_halt, .lk_tx_valid, .lk_tx_data, .lk_tx_ready);

// ### bench/ctf_card_model.sv
// Card module model on the far side of the tunnel link.
// Assumes send is called right after a rising clock edge.
`timescale 1ns/1ps
module ctf_card_model (
   // Clock and pacing
   input  wire logic       pclk,
   input  wire logic       stall,
   // Frames from the front end
   input  wire logic       lk_tx_valid,
   input  wire logic [7:0] lk_tx_data,
   input  wire logic       lk_tx_last,
   output logic            lk_tx_ready,
   // Frames to the front end
   output logic            lk_rx_valid,
   output logic [7:0]      lk_rx_data,
   output logic            lk_rx_last,
   input  wire logic       lk_rx_ready
);
   logic [8:0] got_q[$];
   logic       tog = 1'b0;
   initial begin
      lk_rx_valid = 1'b0;
      lk_rx_data = 8'h00;
      lk_rx_last = 1'b0;
   end
   assign lk_tx_ready = !stall || tog;
   always @(posedge pclk) begin
      tog <= ~tog;
      if (lk_tx_valid && lk_tx_ready)
         got_q.push_back({lk_tx_last, lk_tx_data});
   end
   task automatic send(input logic [7:0] q[$]);
      for (int k = 0; k < q.size(); k++) begin
         lk_rx_valid <= 1'b1;
         lk_rx_data <= q[k];
         lk_rx_last <= (k == q.size() - 1);
         do @(posedge pclk); while (lk_rx_ready !== 1'b1);
      end
      lk_rx_valid <= 1'b0;
      lk_rx_last <= 1'b0;
      lk_rx_data <= ~lk_rx_data;
   endtask
endmodule

// ### bench/ctf_codec_bench.sv
// Self-checking bench of the tunnel frame codec.
// Assumes the card model and checker are compiled first.
`timescale 1ns/1ps
module ctf_codec_bench;
   localparam logic [3:0] TX_ADM [4] = '{4'h0, 4'h8, 4'h9, 4'h5};
   localparam logic [3:0] RX_ADM [4] = '{4'h1, 4'h2, 4'h0, 4'h8};
   localparam int         RX_LEN [4] = '{10, 1, 0, 3};
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00, rf_rx_data = 8'h00, b;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0]  rf_rx_nbits = 4'h0;
   logic        rf_rx_valid = 1'b0, rf_rx_last = 1'b0, rf_tx_ready = 1'b0, card_stall = 1'b0, err, s;
   logic        pready, pslverr, rf_rx_ready, lk_tx_valid, lk_tx_last, lk_tx_ready, lk_rx_valid;
   logic        lk_rx_last, lk_rx_ready, rf_tx_valid, rf_tx_last, rf_goto_init, rf_goto_halt;
   logic [7:0]  lk_tx_data, lk_rx_data, rf_tx_data, rf_tx_bits, rf_bits, pay[$];
   logic [8:0]  exp_q[$], rf_q[$];
   int          failures = 0, check_count = 0, cyc = 0, n_init, n_halt, seed = 75769, i, n, len;
   ctf_codec u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .rf_rx_valid, .rf_rx_data, .rf_rx_last, .rf_rx_nbits, .rf_rx_ready, .lk_tx_valid, .lk_tx_data,
      .lk_tx_last, .lk_tx_ready, .lk_rx_valid, .lk_rx_data, .lk_rx_last, .lk_rx_ready, .rf_tx_valid,
      .rf_tx_data, .rf_tx_last, .rf_tx_bits, .rf_tx_ready, .rf_goto_init, .rf_goto_halt);
   ctf_card_model u_card (.pclk, .stall(card_stall), .lk_tx_valid, .lk_tx_data, .lk_tx_last, .lk_tx_ready,
      .lk_rx_valid, .lk_rx_data, .lk_rx_last, .lk_rx_ready);
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      rf_tx_ready <= $random(seed);
      if (rf_tx_valid && rf_tx_ready) begin
         rf_q.push_back({rf_tx_last, rf_tx_data});
         rf_bits <= rf_tx_bits;
      end
      if (rf_goto_init)
         n_init++;
      if (rf_goto_halt)
         n_halt++;
      if (cyc == 40000) begin
         failures++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      if (failures == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %0t got %0h expected %0h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rf_send(input int cnt, input int nb);
      for (int k = 0; k < cnt; k++) begin
         b = $random(seed);
         rf_rx_valid <= 1'b1;
         rf_rx_data <= b;
         rf_rx_last <= (k == cnt - 1);
         rf_rx_nbits <= nb[3:0];
         if (k == cnt - 1)
            b = b & ((8'h01 << nb) - 8'h01);
         exp_q.push_back({k == cnt - 1, b});
         do @(posedge pclk); while (rf_rx_ready !== 1'b1);
      end
      rf_rx_valid <= 1'b0;
      rf_rx_last <= 1'b0;
      rf_rx_data <= ~rf_rx_data;
   endtask
   task automatic cmp_q(ref logic [8:0] got[$], ref logic [8:0] exp[$]);
      n = 0;
      while (got.size() < exp.size() && n < 600) begin
         @(posedge pclk);
         n++;
      end
      repeat (10) @(posedge pclk);
      chk(got.size(), exp.size());
      foreach (exp[k])
         chk(got[k], exp[k]);
      got.delete();
      exp.delete();
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      chk({rd, err}, 33'h1);
      for (i = 0; i < 4; i++) begin
         s = i[0];
         card_stall <= i[1];
         apb(1'b1, 8'h00, {26'h0, TX_ADM[i], s, 1'b1});
         exp_q.push_back({4'b0010, s, (TX_ADM[i] inside {4'h0, 4'h8, 4'h9}) ? TX_ADM[i] : 4'h0});
         rf_send(i + 1, 1 + {$random(seed)} % 8);
         cmp_q(u_card.got_q, exp_q);
      end
      apb(1'b1, 8'h00, 32'h1);
      rf_send(30, 8);
      exp_q.delete();
      cmp_q(u_card.got_q, exp_q);
      for (i = 0; i < 4; i++) begin
         len = RX_LEN[i];
         s = i[1];
         pay = '{{3'b010, s, RX_ADM[i]}};
         for (int k = 0; k < len; k++) begin
            b = $random(seed);
            pay.push_back(b);
            exp_q.push_back({k == len - 1, b});
         end
         n_init = 0;
         n_halt = 0;
         u_card.send(pay);
         cmp_q(rf_q, exp_q);
         if (len > 0)
            chk(rf_bits, s ? 8 * len : (len == 1 ? 4 : 9 * (8 * len / 9)));
         chk(n_init * 2 + n_halt, (RX_ADM[i] == 4'h1) * 2 + (RX_ADM[i] == 4'h2));
         apb(1'b0, 8'h04, 32'h0);
         chk({rd[19:16], rd[12:8]}, {RX_ADM[i], len[4:0]});
      end
      pay = '{8'h20, 8'h55};
      u_card.send(pay);
      cmp_q(rf_q, exp_q);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd[5:4], 2'b11);
      apb(1'b1, 8'h04, 32'h30);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd[5:4], 2'b00);
      print_verdict();
   end
endmodule
